// ==== dv/dre_cmd_status_properties.sv ====
`timescale 1ns/1ps
// Port-level checks of the command and status block.
module dre_cmd_status_props
  import dre_pkg::*;
#(
  parameter int SLOTS = 8
) (
  input wire logic core_clk, // Clock.
  input wire logic reset, // Reset.
  input wire logic [15:0] io_addr, // Address.
  input wire logic io_wr, // Write.
  input wire logic io_rd, // Read.
  input wire logic [15:0] io_wdata, // Write data.
  input wire logic [15:0] io_rdata, // Read data.
  input wire logic io_rvalid, // Read answer.
  input wire logic engine_start, // Launch.
  input wire logic engine_done, // Finish.
  input wire logic engine_active, // Busy.
  input wire logic queue_all_empty, // Empty.
  input wire logic direction_kind, // Radial.
  input wire logic [2:0] draw_direction, // Direction.
  input wire logic [2:0] radial_octant, // Angle.
  input wire logic axial_y_down, // Down.
  input wire logic axial_y_major, // Y major.
  input wire logic axial_x_right, // Right.
  input wire logic host_data_wait, // Host data.
  input wire logic px_valid, // Pixel word.
  input wire logic [1:0] xfer_width, // Width.
  input wire logic draw_stall, // Stall.
  input wire logic [11:0] second_edge_axis_count // Edge count.
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // A command write that finds the engine idle and nothing queued.
  sequence s_cmd_idle;
    io_wr && io_addr == DRE_ADDR_STATUS_CMD && io_wdata[15:13] != 3'h0 &&
      queue_all_empty && !engine_active;
  endsequence
  // Launch cycle followed by a run cycle.
  sequence s_launch_run;
    engine_active && engine_start ##1 engine_active && !engine_start;
  endsequence
  sequence s_stat_rd;
    io_rd && io_addr == DRE_ADDR_STATUS_CMD;
  endsequence

  a_rd_valid: assert property (io_rd |=> io_rvalid)
    else $error("read not answered");
  a_busy_bit: assert property (s_stat_rd |=> io_rdata[9] == $past(engine_active))
    else $error("busy bit wrong");
  a_empty_bit: assert property (s_stat_rd |=> io_rdata[10] == $past(queue_all_empty))
    else $error("empty bit wrong");
  a_queue_fill: assert property (s_cmd_idle |=> !queue_all_empty)
    else $error("queue still empty");
  a_cmd_launch: assert property (s_cmd_idle |-> ##2 s_launch_run)
    else $error("command not launched");
  a_done_idle: assert property (engine_active && !engine_start && engine_done |=> !engine_active)
    else $error("still busy after done");
  a_radial_dir: assert property (direction_kind |-> radial_octant == draw_direction &&
    {axial_y_down, axial_y_major, axial_x_right} == 3'h0) else $error("radial decode");
  a_axial_dir: assert property (!direction_kind |-> radial_octant == 3'h0 &&
    {axial_y_down, axial_y_major, axial_x_right} == draw_direction) else $error("axial decode");
  a_draw_stall: assert property (draw_stall == (engine_active && host_data_wait && !px_valid))
    else $error("stall wrong");
  a_edge_count: assert property (io_wr && io_addr == DRE_ADDR_SECOND_EDGE |=>
    {4'h0, second_edge_axis_count} == ($past(io_wdata) & 16'h0fff)) else $error("edge count");
  a_px_word: assert property (io_wr && io_addr == DRE_ADDR_PIXEL_LO && !xfer_width[1] |=> px_valid)
    else $error("pixel word missing");
endmodule : dre_cmd_status_props

bind dre_cmd_status dre_cmd_status_props #(.SLOTS(SLOTS)) props_inst (
  .core_clk(core_clk), .reset(reset), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
  .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid), .engine_start(engine_start),
  .engine_done(engine_done), .engine_active(engine_active), .queue_all_empty(queue_all_empty),
  .direction_kind(direction_kind), .draw_direction(draw_direction), .radial_octant(radial_octant),
  .axial_y_down(axial_y_down), .axial_y_major(axial_y_major), .axial_x_right(axial_x_right),
  .host_data_wait(host_data_wait), .px_valid(px_valid), .xfer_width(xfer_width),
  .draw_stall(draw_stall), .second_edge_axis_count(second_edge_axis_count));

// ==== dv/dre_host_model.sv ====
`timescale 1ns/1ps
// Host processor issuing I/O cycles; one idle cycle separates transfers.
module dre_host_model
  import dre_pkg::*;
(
  input wire logic core_clk, // Clock.
  output logic [15:0] io_addr, // Address.
  output logic io_wr, // Write strobe.
  output logic io_rd, // Read strobe.
  output logic [15:0] io_wdata, // Write data.
  input wire logic [15:0] io_rdata, // Read data.
  input wire logic io_rvalid // Read answer.
);
  initial begin
    io_addr = 16'h0;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 16'h0;
  end

  // Released lines are inverted so a stale value is never mistaken for a live one.
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk);
    #1;
    io_addr = a;
    io_wdata = (a == DRE_ADDR_STATUS_CMD) ? (d | 16'h0001) : d;
    io_wr = 1'b1;
    @(posedge core_clk);
    #1;
    io_wr = 1'b0;
    io_addr = ~io_addr;
    io_wdata = ~io_wdata;
  endtask : wr

  // The answer is taken at the edge after the strobe, where it stands.
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge core_clk);
    #1;
    io_addr = a;
    io_rd = 1'b1;
    @(posedge core_clk);
    #1;
    io_rd = 1'b0;
    io_addr = ~io_addr;
    d = io_rvalid ? io_rdata : 16'hxxxx;
  endtask : rd
endmodule : dre_host_model

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
// Self-checking bench: queue model with integers and a queue of command words.
module testbench;
  import dre_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic engine_done = 1'b0;
  logic px_take = 1'b0;
  logic [15:0] io_addr, io_wdata, io_rdata;
  logic io_wr, io_rd, io_rvalid, engine_start, cmd_type_known, across_plane_select;
  logic final_pixel_skip, direction_kind, pixel_write_enable, axial_y_down, axial_y_major;
  logic axial_x_right, host_data_wait, byte_order_swap, line_fresh_dword, line_next_byte;
  logic px_valid, draw_stall, engine_active, queue_all_empty;
  logic [3:0] cmd_type;
  logic [2:0] draw_direction, radial_octant;
  logic [1:0] xfer_width;
  logic [11:0] second_edge_axis_count;
  logic [31:0] px_data;
  logic [15:0] q[$];
  logic [15:0] cmds[4] = '{16'h2111, 16'h2311, 16'h3311, 16'h2511};
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;
  int seed = 8122;
  wire [17:0] dec_now = {cmd_type, cmd_type_known, across_plane_select, final_pixel_skip,
    direction_kind, pixel_write_enable, draw_direction, host_data_wait, byte_order_swap,
    xfer_width, line_fresh_dword, line_next_byte};

  dre_cmd_status #(.SLOTS(DRE_SLOTS_SMALL)) dre_cmd_status_inst (
    .core_clk(core_clk), .reset(reset), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid), .engine_start(engine_start),
    .engine_done(engine_done), .cmd_type(cmd_type), .cmd_type_known(cmd_type_known),
    .across_plane_select(across_plane_select), .final_pixel_skip(final_pixel_skip),
    .direction_kind(direction_kind), .pixel_write_enable(pixel_write_enable),
    .draw_direction(draw_direction), .radial_octant(radial_octant), .axial_y_down(axial_y_down),
    .axial_y_major(axial_y_major), .axial_x_right(axial_x_right), .host_data_wait(host_data_wait),
    .byte_order_swap(byte_order_swap), .xfer_width(xfer_width), .line_fresh_dword(line_fresh_dword),
    .line_next_byte(line_next_byte), .second_edge_axis_count(second_edge_axis_count),
    .px_valid(px_valid), .px_data(px_data), .px_take(px_take), .draw_stall(draw_stall),
    .engine_active(engine_active), .queue_all_empty(queue_all_empty));
  dre_host_model host (.core_clk(core_clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and a cycle ceiling well above the 155 or so cycles the run needs.
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      results();
    end
  end

  task automatic report(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : report
  task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp);
    report({16'h0, got}, {16'h0, exp});
  endtask : cmp_reg
  task automatic cmp_dec(input logic [17:0] got, input logic [17:0] exp);
    report({14'h0, got}, {14'h0, exp});
  endtask : cmp_dec
  task automatic cmp_px(input logic [31:0] got, input logic [31:0] exp);
    report(got, exp);
  endtask : cmp_px

  // Status model: one thermometer bit per occupied slot from the low end.
  function automatic logic [15:0] exp_stat(input int n, input logic busy);
    exp_stat = 16'((1 << n) - 1);
    exp_stat[9] = busy;
    exp_stat[10] = (n == 0);
  endfunction : exp_stat
  function automatic logic [17:0] exp_dec(input logic [15:0] w);
    logic [3:0] t;
    t = {w[11], w[15:13]};
    exp_dec = {t, t inside {[4'h0:4'h7], 4'h9, [4'hb:4'hd]}, w[1], w[2], w[3], w[4], w[7:5],
      w[8], w[12], w[10:9], w[10] && !(w[9] && w[1]), w[10] && w[9] && w[1]};
  endfunction : exp_dec

  // Launch is bounded: a queued command must start within ten cycles.
  task automatic wait_start();
    int n;
    n = 0;
    while (engine_start !== 1'b1 && n < 10) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    cmp_px({31'h0, engine_start}, 32'h1);
  endtask : wait_start
  task automatic pulse(ref logic s);
    @(posedge core_clk);
    #1;
    s = 1'b1;
    @(posedge core_clk);
    #1;
    s = 1'b0;
  endtask : pulse

  task automatic results();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  initial begin
    logic [15:0] w, d, r;
    logic [31:0] e;
    repeat (10) @(posedge core_clk);
    #1;
    reset = 1'b0;
    host.rd(DRE_ADDR_STATUS_CMD, r);
    cmp_reg(r, exp_stat(0, 1'b0));
    repeat (3) begin
      d = 16'($random(seed));
      host.wr(DRE_ADDR_SECOND_EDGE, d);
      host.rd(DRE_ADDR_SECOND_EDGE, r);
      cmp_reg(r, d & 16'h0fff);
    end
    host.rd(16'h1234, r);
    cmp_reg(r, 16'h0000);
    // Fill: the first command runs and holds, eight queue, the tenth is dropped.
    for (int i = 0; i < 10; i++) begin
      w = 16'($random(seed)) | 16'h0001;
      if (w[15:13] == 3'h0) w[13] = 1'b1;
      host.wr(DRE_ADDR_STATUS_CMD, w);
      if (i == 0) begin
        wait_start();
        cmp_dec(dec_now, exp_dec(w));
      end else if (q.size() < DRE_SLOTS_SMALL) begin
        q.push_back(w);
      end
      host.rd(DRE_ADDR_STATUS_CMD, r);
      cmp_reg(r, exp_stat(q.size(), 1'b1));
    end
    // Drain in order, one completion at a time.
    while (q.size() > 0) begin
      w = q.pop_front();
      pulse(engine_done);
      wait_start();
      cmp_dec(dec_now, exp_dec(w));
      host.rd(DRE_ADDR_STATUS_CMD, r);
      cmp_reg(r, exp_stat(q.size(), 1'b1));
    end
    pulse(engine_done);
    host.wr(DRE_ADDR_STATUS_CMD, 16'h0001);
    repeat (4) begin
      @(posedge core_clk);
      #1;
      cmp_px({31'h0, engine_start}, 32'h0);
    end
    host.rd(DRE_ADDR_STATUS_CMD, r);
    cmp_reg(r, exp_stat(0, 1'b0));
    // Pixel port at widths 8, 16 and 32 (dword), and both byte orders at 16 bits, with the engine waiting on host data.
    for (int i = 0; i < 4; i++) begin
      host.wr(DRE_ADDR_STATUS_CMD, cmds[i]);
      wait_start();
      cmp_dec(dec_now, exp_dec(cmds[i]));
      cmp_px({31'h0, draw_stall}, 32'h1);
      d = 16'($random(seed));
      e = (i == 0) ? {24'h0, d[7:0]} : (i == 2) ? {16'h0, d[7:0], d[15:8]} : {16'h0, d};
      host.wr(DRE_ADDR_PIXEL_LO, d);
      if (i == 3) begin
        e[31:16] = 16'($random(seed));
        host.wr(DRE_ADDR_PIXEL_HI, e[31:16]);
      end
      cmp_px({31'h0, px_valid}, 32'h1);
      cmp_px(px_data, e);
      cmp_px({31'h0, draw_stall}, 32'h0);
      pulse(px_take);
      cmp_px({31'h0, px_valid}, 32'h0);
      pulse(engine_done);
    end
    results();
  end
endmodule : testbench

// ==== rtl/dre_cmd_queue.sv ====
`timescale 1ns/1ps
module dre_cmd_queue
  import dre_pkg::*;
#(
  parameter int SLOTS = 8
) (
  input wire logic core_clk,  // Engine clock.
  input wire logic reset,     // Asynchronous reset, active high.
  dre_queue_if.store q        // Push and pop side.
);

  localparam int PW = $clog2(SLOTS);
  localparam int CW = $clog2(SLOTS+1);

  logic [15:0] slot_q [SLOTS];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;
  logic do_push;
  logic do_pop;

  // A push into a full queue is dropped; the host must poll the status first.
  assign do_push = q.push && (count_q != CW'(SLOTS));
  assign do_pop = q.pop && (count_q != '0);

  //////////////////////////////////////////////////////////////////////////////
  // Slot storage, written only on an accepted push.
  always_ff @(posedge core_clk) begin
    if (do_push) begin
      slot_q[wr_ptr_q] <= q.push_word;
    end
  end

  // Pointers wrap at the slot count, which need not be a power of two.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_q <= (wr_ptr_q == PW'(SLOTS-1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_q <= (rd_ptr_q == PW'(SLOTS-1)) ? '0 : rd_ptr_q + 1'b1;
      end
    end
  end

  // Occupancy count, untouched when push and pop meet.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      count_q <= '0;
    end else if (do_push && !do_pop) begin
      count_q <= count_q + 1'b1;
    end else if (do_pop && !do_push) begin
      count_q <= count_q - 1'b1;
    end
  end

  assign q.head_word = slot_q[rd_ptr_q];
  assign q.count = count_q;
  assign q.empty = (count_q == '0);
  assign q.full = (count_q == CW'(SLOTS));

endmodule : dre_cmd_queue

// ==== rtl/dre_cmd_status.sv ====
`timescale 1ns/1ps
module dre_cmd_status
  import dre_pkg::*;
#(
  parameter int SLOTS = DRE_SLOTS_SMALL
) (
  input wire logic core_clk,                     // Engine clock, 50 MHz.
  input wire logic reset,                        // Asynchronous reset, active high.
  input wire logic [15:0] io_addr,               // Host I/O address.
  input wire logic io_wr,                        // Host write strobe.
  input wire logic io_rd,                        // Host read strobe.
  input wire logic [15:0] io_wdata,              // Host write data.
  output logic [15:0] io_rdata,                  // Read data, registered.
  output logic io_rvalid,                        // Read data valid pulse.
  output logic engine_start,                     // Command launch pulse.
  input wire logic engine_done,                  // Rasterizer finished the command.
  output logic [3:0] cmd_type,                   // Decoded command type.
  output logic cmd_type_known,                   // Type is a defined code.
  output logic across_plane_select,              // Multi-pixel transfer mode.
  output logic final_pixel_skip,                 // Omit last pixel.
  output logic direction_kind,                   // 1 radial, 0 axial.
  output logic pixel_write_enable,               // 0 moves position only.
  output logic [2:0] draw_direction,             // Raw direction field.
  output logic [2:0] radial_octant,              // Angle in 45 degree steps.
  output logic axial_y_down,                     // Axial vertical sign.
  output logic axial_y_major,                    // Axial major axis is Y.
  output logic axial_x_right,                    // Axial horizontal sign.
  output logic host_data_wait,                   // Draw uses host pixel data.
  output logic byte_order_swap,                  // Low byte first when set.
  output logic [1:0] xfer_width,                 // Pixel port width code.
  output logic line_fresh_dword,                 // Each line on a new doubleword.
  output logic line_next_byte,                   // Each line at the next byte.
  output logic [DRE_EDGE_W-1:0] second_edge_axis_count, // Second edge length - 1.
  output logic px_valid,                         // Host pixel word is pending.
  output logic [31:0] px_data,                   // Host pixel data, ordered.
  input wire logic px_take,                      // Rasterizer consumes pixel word.
  output logic draw_stall,                       // Drawing held for host data.
  output logic engine_active,                    // Command executing.
  output logic queue_all_empty                   // No command queued.
);

  if (SLOTS != DRE_SLOTS_SMALL && SLOTS != DRE_SLOTS_LARGE) begin : g_check
    $error("dre_cmd_status: SLOTS must be 8 or 13");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Field decoders shared by launch and status logic.

  function automatic logic [3:0] type_of(input logic [15:0] w);
    type_of = {w[DRE_CMD_TYPE_HI_BIT], w[DRE_CMD_TYPE_LSB +: 3]};
  endfunction : type_of

  function automatic logic type_known(input logic [3:0] t);
    unique case (t)
      DRE_CT_NOP, DRE_CT_LINE, DRE_CT_RECT, DRE_CT_POLY, DRE_CT_TRAP4,
      DRE_CT_BRES, DRE_CT_BLIT, DRE_CT_PATBLIT, DRE_CT_POLYLINE,
      DRE_CT_POLY_PAT, DRE_CT_TRAP4_PAT, DRE_CT_BRES_PAT: type_known = 1'b1;
      default: type_known = 1'b0;
    endcase
  endfunction : type_known

  function automatic logic is_addr(input logic [15:0] a, input logic [15:0] ref_a);
    is_addr = (a == ref_a);
  endfunction : is_addr

  //////////////////////////////////////////////////////////////////////////////
  // Queue and thermometer encoder.

  dre_queue_if #(.SLOTS(SLOTS)) q ();

  dre_cmd_queue #(.SLOTS(SLOTS)) u_queue (
    .core_clk(core_clk),
    .reset(reset),
    .q(q)
  );

  logic [15:0] therm;

  dre_therm_enc #(.SLOTS(SLOTS)) u_therm (
    .count(q.count),
    .therm(therm)
  );

  logic wr_cmd;
  logic wr_edge;
  logic wr_px_lo;
  logic wr_px_hi;

  // One address: a write loads a command, a read returns status.
  assign wr_cmd = io_wr && is_addr(io_addr, DRE_ADDR_STATUS_CMD);
  assign wr_edge = io_wr && is_addr(io_addr, DRE_ADDR_SECOND_EDGE);
  assign wr_px_lo = io_wr && is_addr(io_addr, DRE_ADDR_PIXEL_LO);
  assign wr_px_hi = io_wr && is_addr(io_addr, DRE_ADDR_PIXEL_HI);

  // Bit 0 is not checked; the host keeps it at one and the word is queued whole.
  assign q.push = wr_cmd;
  assign q.push_word = io_wdata;

  //////////////////////////////////////////////////////////////////////////////
  // Execution sequencer.

  dre_seq_t state_q;
  dre_seq_t state_d;
  logic [15:0] cur_q;
  logic launch;

  // A queued word is taken only while idle, so status follows occupancy.
  assign launch = (state_q == DRE_ST_IDLE) && !q.empty;
  assign q.pop = launch;

  // A no-operation only sets up state and ends without starting the rasterizer.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      DRE_ST_IDLE: begin
        if (!q.empty) begin
          state_d = (type_of(q.head_word) == DRE_CT_NOP) ? DRE_ST_IDLE : DRE_ST_LAUNCH;
        end
      end
      DRE_ST_LAUNCH: begin
        state_d = DRE_ST_RUN;
      end
      DRE_ST_RUN: begin
        if (engine_done) begin
          state_d = DRE_ST_IDLE;
        end
      end
      default: begin
        state_d = DRE_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q <= DRE_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Current command word, held for the rasterizer while it executes.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cur_q <= DRE_WORD_RST;
    end else if (launch) begin
      cur_q <= q.head_word;
    end
  end

  assign engine_start = (state_q == DRE_ST_LAUNCH);
  assign engine_active = (state_q != DRE_ST_IDLE);
  assign queue_all_empty = q.empty;

  //////////////////////////////////////////////////////////////////////////////
  // Decoded command fields.

  assign cmd_type = type_of(cur_q);
  assign across_plane_select = cur_q[DRE_CMD_ACROSS_BIT];
  assign final_pixel_skip = cur_q[DRE_CMD_SKIP_BIT];
  assign direction_kind = cur_q[DRE_CMD_KIND_BIT];
  assign pixel_write_enable = cur_q[DRE_CMD_DRAW_BIT];
  assign draw_direction = cur_q[DRE_CMD_DIR_LSB +: 3];
  assign host_data_wait = cur_q[DRE_CMD_WAIT_BIT];
  assign byte_order_swap = cur_q[DRE_CMD_SWAP_BIT];
  assign xfer_width = cur_q[DRE_CMD_BUS_LSB +: 2];

  // Derived fields are taken at launch from the word being popped, so they
  // move in step with the current word and come straight from flip-flops.
  logic [15:0] nxt;
  logic [1:0] nxt_bw;
  logic known_q;
  logic [2:0] octant_q;
  logic [2:0] axial_q;
  logic fresh_q;
  logic next_byte_q;

  assign nxt = q.head_word;
  assign nxt_bw = nxt[DRE_CMD_BUS_LSB +: 2];

  // Radial code is a count of 45 degree steps; axial bits are zero in radial mode.
  // Line-end handling for host image writes; code 11 only means byte packing
  // in across-the-plane mode, otherwise it behaves as a plain 32-bit width.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      known_q <= 1'b1;
      octant_q <= 3'h0;
      axial_q <= 3'h0;
      fresh_q <= 1'b0;
      next_byte_q <= 1'b0;
    end else if (launch) begin
      known_q <= type_known(type_of(nxt));
      octant_q <= nxt[DRE_CMD_KIND_BIT] ? nxt[DRE_CMD_DIR_LSB +: 3] : 3'h0;
      axial_q <= nxt[DRE_CMD_KIND_BIT] ? 3'h0 : nxt[DRE_CMD_DIR_LSB +: 3];
      fresh_q <= (nxt_bw == DRE_BW_32_DWORD) ||
                 (nxt_bw == DRE_BW_32_BYTE && !nxt[DRE_CMD_ACROSS_BIT]);
      next_byte_q <= (nxt_bw == DRE_BW_32_BYTE) && nxt[DRE_CMD_ACROSS_BIT];
    end
  end

  assign cmd_type_known = known_q;
  assign radial_octant = octant_q;
  assign {axial_y_down, axial_y_major, axial_x_right} = axial_q;
  assign line_fresh_dword = fresh_q;
  assign line_next_byte = next_byte_q;

  //////////////////////////////////////////////////////////////////////////////
  // Second-edge axis count register.

  logic [DRE_EDGE_W-1:0] edge_q;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      edge_q <= DRE_EDGE_RST;
    end else if (wr_edge) begin
      edge_q <= io_wdata[DRE_EDGE_W-1:0];
    end
  end

  assign second_edge_axis_count = edge_q;

  //////////////////////////////////////////////////////////////////////////////
  // Pixel data port. Width and byte order shape only these writes.

  logic [15:0] lane;
  logic [31:0] px_q;
  logic px_pend_q;
  logic px_word_done;

  // Bytes of a host word are taken in the order the command selects.
  assign lane = byte_order_swap ? {io_wdata[7:0], io_wdata[15:8]} : io_wdata;

  // An 8 or 16 bit transfer completes on either port write; a 32 bit one on
  // the upper half.
  assign px_word_done = (wr_px_lo && xfer_width[1] == 1'b0) || wr_px_hi;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      px_q <= 32'h0000_0000;
    end else if (wr_px_lo) begin
      px_q <= (xfer_width == DRE_BW_8) ? {24'h00_0000, lane[7:0]} : {16'h0000, lane};
    end else if (wr_px_hi) begin
      px_q <= {lane, px_q[15:0]};
    end
  end

  // A new word arriving in the same cycle as a take keeps the flag set.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      px_pend_q <= 1'b0;
    end else if (px_word_done) begin
      px_pend_q <= 1'b1;
    end else if (px_take) begin
      px_pend_q <= 1'b0;
    end
  end

  assign px_valid = px_pend_q;
  assign px_data = px_q;

  // The rasterizer must hold while waiting for host data and none is ready.
  assign draw_stall = engine_active && host_data_wait && !px_pend_q;

  //////////////////////////////////////////////////////////////////////////////
  // Host reads. Unmapped and write-only addresses read as zero.

  logic [15:0] status_word;

  always_comb begin
    status_word = therm;
    status_word[DRE_STAT_BUSY_BIT] = engine_active;
    status_word[DRE_STAT_EMPTY_BIT] = q.empty;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      io_rdata <= DRE_WORD_RST;
      io_rvalid <= 1'b0;
    end else begin
      io_rvalid <= io_rd;
      if (io_rd && is_addr(io_addr, DRE_ADDR_STATUS_CMD)) begin
        io_rdata <= status_word;
      end else if (io_rd && is_addr(io_addr, DRE_ADDR_SECOND_EDGE)) begin
        io_rdata <= {{(16-DRE_EDGE_W){1'b0}}, edge_q};
      end else begin
        io_rdata <= DRE_WORD_RST;
      end
    end
  end

endmodule : dre_cmd_status

// ==== rtl/dre_pkg.sv ====
package dre_pkg;

  // Host I/O addresses of the block.
  localparam logic [15:0] DRE_ADDR_SECOND_EDGE = 16'h96ea;
  localparam logic [15:0] DRE_ADDR_STATUS_CMD = 16'h9ae8;
  localparam logic [15:0] DRE_ADDR_PIXEL_LO = 16'he2e8;
  localparam logic [15:0] DRE_ADDR_PIXEL_HI = 16'he2ea;

  // Command word field positions.
  localparam int DRE_CMD_ONE_BIT = 0;
  localparam int DRE_CMD_ACROSS_BIT = 1;
  localparam int DRE_CMD_SKIP_BIT = 2;
  localparam int DRE_CMD_KIND_BIT = 3;
  localparam int DRE_CMD_DRAW_BIT = 4;
  localparam int DRE_CMD_DIR_LSB = 5;
  localparam int DRE_CMD_WAIT_BIT = 8;
  localparam int DRE_CMD_BUS_LSB = 9;
  localparam int DRE_CMD_TYPE_HI_BIT = 11;
  localparam int DRE_CMD_SWAP_BIT = 12;
  localparam int DRE_CMD_TYPE_LSB = 13;

  // Status word field positions.
  localparam int DRE_STAT_LO_W = 8;
  localparam int DRE_STAT_BUSY_BIT = 9;
  localparam int DRE_STAT_EMPTY_BIT = 10;
  localparam int DRE_STAT_HI_LSB = 11;

  // Second-edge count width and values after reset.
  localparam int DRE_EDGE_W = 12;
  localparam logic [11:0] DRE_EDGE_RST = 12'h000;
  localparam logic [15:0] DRE_WORD_RST = 16'h0000;

  // Documented queue depths.
  localparam int DRE_SLOTS_SMALL = 8;
  localparam int DRE_SLOTS_LARGE = 13;

  // Transfer width codes.
  localparam logic [1:0] DRE_BW_8 = 2'h0;
  localparam logic [1:0] DRE_BW_16 = 2'h1;
  localparam logic [1:0] DRE_BW_32_DWORD = 2'h2;
  localparam logic [1:0] DRE_BW_32_BYTE = 2'h3;

  typedef enum logic [3:0] {
    DRE_CT_NOP = 4'h0,
    DRE_CT_LINE = 4'h1,
    DRE_CT_RECT = 4'h2,
    DRE_CT_POLY = 4'h3,
    DRE_CT_TRAP4 = 4'h4,
    DRE_CT_BRES = 4'h5,
    DRE_CT_BLIT = 4'h6,
    DRE_CT_PATBLIT = 4'h7,
    DRE_CT_POLYLINE = 4'h9,
    DRE_CT_POLY_PAT = 4'hb,
    DRE_CT_TRAP4_PAT = 4'hc,
    DRE_CT_BRES_PAT = 4'hd
  } dre_ctype_t;

  typedef enum logic [2:0] {
    DRE_ST_IDLE = 3'b001,
    DRE_ST_LAUNCH = 3'b010,
    DRE_ST_RUN = 3'b100
  } dre_seq_t;

endpackage : dre_pkg

// ==== rtl/dre_queue_if.sv ====
`timescale 1ns/1ps
// Command queue carrier between the interpreter and its queue.
interface dre_queue_if #(
  parameter int SLOTS = 8
);
  logic push;
  logic [15:0] push_word;
  logic pop;
  logic [15:0] head_word;
  logic [$clog2(SLOTS+1)-1:0] count;
  logic empty;
  logic full;

  modport owner (output push, output push_word, output pop,
                 input head_word, input count, input empty, input full);
  modport store (input push, input push_word, input pop,
                 output head_word, output count, output empty, output full);
endinterface : dre_queue_if

// ==== rtl/dre_therm_enc.sv ====
`timescale 1ns/1ps
module dre_therm_enc
  import dre_pkg::*;
#(
  parameter int SLOTS = 8
) (
  input wire logic [$clog2(SLOTS+1)-1:0] count,  // Occupied slots.
  output logic [15:0] therm                      // Queue field in status layout.
);

  // Status bit n, for n up to SLOTS, is set once fewer than n slots are free; bit 1 sits at
  // register bit 7 going down, bits 9 to 13 sit at register bits 15 to 11.
  genvar n;
  generate
    for (n = 1; n <= 13; n++) begin : g_bit
      localparam int POS = (n <= DRE_STAT_LO_W) ? (8 - n) : (24 - n);
      if (n <= SLOTS) begin : g_used
        assign therm[POS] = (32'(count) >= (SLOTS - n + 1));
      end else begin : g_unused
        assign therm[POS] = 1'b0;
      end
    end
  endgenerate

  // Bit 8 is unused; bits 9 and 10 belong to other status fields.
  assign therm[8] = 1'b0;
  assign therm[DRE_STAT_BUSY_BIT] = 1'b0;
  assign therm[DRE_STAT_EMPTY_BIT] = 1'b0;

endmodule : dre_therm_enc
